// *** uid_pkg.sv ***
// package: register map, codes and field positions of the interrupt and dma block
package uid_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] OFS_IER  = 8'h00;
   localparam logic [7:0] OFS_FCR  = 8'h04;
   localparam logic [7:0] OFS_IIR  = 8'h08;
   localparam logic [7:0] OFS_LSR  = 8'h0c;
   localparam logic [7:0] OFS_MSR  = 8'h10;
   localparam logic [7:0] OFS_DATA = 8'h14;

   // identification codes
   localparam logic [5:0] CODE_NONE  = 6'h01;
   localparam logic [5:0] CODE_LINE  = 6'h06;
   localparam logic [5:0] CODE_TMO   = 6'h0c;
   localparam logic [5:0] CODE_RXD   = 6'h04;
   localparam logic [5:0] CODE_TXE   = 6'h02;
   localparam logic [5:0] CODE_MODEM = 6'h00;
   localparam logic [5:0] CODE_FLOW  = 6'h10;
   localparam logic [5:0] CODE_HS    = 6'h20;

   // source index into the pending vector, highest priority first
   localparam int SRC_LINE  = 0;
   localparam int SRC_TMO   = 1;
   localparam int SRC_RXD   = 2;
   localparam int SRC_TXE   = 3;
   localparam int SRC_MODEM = 4;
   localparam int SRC_FLOW  = 5;
   localparam int SRC_HS    = 6;
   localparam int NUM_SRC   = 7;

   // interrupt_enable_reg bits
   localparam int IER_RXD   = 0;
   localparam int IER_TXE   = 1;
   localparam int IER_LINE  = 2;
   localparam int IER_MODEM = 3;
   localparam int IER_FLOW  = 5;
   localparam int IER_RTS   = 6;
   localparam int IER_CTS   = 7;

   // fifo_control_reg bits
   localparam int FCR_FIFO_EN  = 0;
   localparam int FCR_DMA_MODE = 3;

   // reset values
   localparam logic [7:0] IER_RESET = 8'h00;
   localparam logic [7:0] FCR_RESET = 8'h00;
   localparam logic [5:0] IIR_RESET = CODE_NONE;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // handshake pin index
   localparam int PIN_CTS = 0;
   localparam int PIN_RTS = 1;
endpackage : uid_pkg

// *** uid_prio.sv ***
// priority encoder: picks the highest pending enabled source
`timescale 1ns/1ps
module uid_prio (
   // enabled pending sources
   input  wire logic [uid_pkg::NUM_SRC-1:0] pending,
   // winner
   output logic      [5:0]                  code,
   output logic      [uid_pkg::NUM_SRC-1:0] grant
);
   import uid_pkg::*;

   always_comb begin
      code  = CODE_NONE;
      grant = '0;
      // lowest index wins; timeout outranks data at the same level
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            grant = '0;
            grant[i] = 1'b1;
            unique case (i)
               SRC_LINE:  code = CODE_LINE;
               SRC_TMO:   code = CODE_TMO;
               SRC_RXD:   code = CODE_RXD;
               SRC_TXE:   code = CODE_TXE;
               SRC_MODEM: code = CODE_MODEM;
               SRC_FLOW:  code = CODE_FLOW;
               default:   code = CODE_HS;
            endcase
         end
      end
   end
endmodule : uid_prio

// *** uid_irq_dma.sv ***
// interrupt prioritisation, identification and dma request logic of one uart channel
`timescale 1ns/1ps
module uid_irq_dma #(
   parameter int DEPTH = 64,
   parameter int CW    = 7
) (
   // clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // axi4-lite slave
   input  wire logic [7:0]      awaddr,
   input  wire logic            awvalid,
   output logic                 awready,
   input  wire logic [31:0]     wdata,
   input  wire logic [3:0]      wstrb,
   input  wire logic            wvalid,
   output logic                 wready,
   output logic [1:0]           bresp,
   output logic                 bvalid,
   input  wire logic            bready,
   input  wire logic [7:0]      araddr,
   input  wire logic            arvalid,
   output logic                 arready,
   output logic [31:0]          rdata,
   output logic [1:0]           rresp,
   output logic                 rvalid,
   input  wire logic            rready,
   // receive side status from the uart core
   input  wire logic [CW-1:0]   rx_count,
   input  wire logic [CW-1:0]   rx_trigger,
   input  wire logic [7:0]      rx_head_data,
   input  wire logic [2:0]      rx_head_errors,
   input  wire logic            rx_error_anywhere,
   input  wire logic            overrun_event,
   input  wire logic            rx_timeout_event,
   // transmit side status from the uart core
   input  wire logic [CW-1:0]   tx_count,
   input  wire logic [CW-1:0]   tx_trigger,
   input  wire logic            tx_shift_empty,
   // modem and flow events
   input  wire logic [3:0]      modem_change,
   input  wire logic [3:0]      modem_lines,
   input  wire logic            flow_stop_event,
   input  wire logic            flow_resume_event,
   input  wire logic            special_char_event,
   input  wire logic            cts_n,
   input  wire logic            rts_n,
   // data strobes to the uart core
   output logic                 rx_pop,
   output logic                 tx_push,
   output logic [7:0]           tx_data,
   output logic [7:0]           fifo_control,
   // interrupt and dma pins
   output logic                 irq_n,
   output logic                 tx_dma_request_n,
   output logic                 rx_dma_request_n
);
   import uid_pkg::*;

   logic [7:0]         interrupt_enable_reg;
   logic [5:0]         interrupt_ident_reg;
   logic [NUM_SRC-1:0] grant_q;
   logic [7:0]         aw_addr_q;
   logic               aw_full;
   logic [31:0]        w_data_q;
   logic [3:0]         w_strb_q;
   logic               w_full;
   logic               overrun_pend;
   logic               tmo_pend;
   logic               txe_pend;
   logic               txe_cond_q;
   logic [3:0]         modem_delta;
   logic               flow_pend;
   logic               flow_by_special;
   logic [1:0]         hs_pend;
   logic [1:0]         pin_s1;
   logic [1:0]         pin_s2;
   logic [1:0]         pin_s3;
   logic [1:0]         pin_stable;
   logic [NUM_SRC-1:0] pending;
   logic [NUM_SRC-1:0] next_grant;
   logic [5:0]         next_code;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic       wr_go;
   logic       ar_go;
   logic       rd_iir;
   logic       rd_lsr;
   logic       rd_msr;
   logic       rd_data;
   logic       wr_thr;
   logic       fifo_en;
   logic       block_mode;
   logic [CW-1:0] tx_space;
   logic       rx_has_data;

   assign wr_go       = aw_full && w_full && !bvalid;
   assign ar_go       = arvalid && !rvalid;
   assign rd_iir      = ar_go && araddr == OFS_IIR;
   assign rd_lsr      = ar_go && araddr == OFS_LSR;
   assign rd_msr      = ar_go && araddr == OFS_MSR;
   assign rd_data     = ar_go && araddr == OFS_DATA;
   assign wr_thr      = wr_go && aw_addr_q == OFS_DATA && w_strb_q[0];
   assign fifo_en     = fifo_control[FCR_FIFO_EN];
   assign block_mode  = fifo_control[FCR_DMA_MODE] && fifo_en;
   assign tx_space    = CW'(DEPTH) - tx_count;
   assign rx_has_data = rx_count != '0;

   // ready lines are flops, so the bus sees no logic after a register
   assign aw_full = !awready;
   assign w_full  = !wready;

   // address and data are held separately so they may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         aw_addr_q <= 8'h00;
      end else if (awvalid && !aw_full) begin
         awready   <= 1'b0;
         aw_addr_q <= awaddr;
      end else if (wr_go) begin
         awready   <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready   <= 1'b1;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (wvalid && !w_full) begin
         wready   <= 1'b0;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (wr_go) begin
         wready   <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= (aw_addr_q == OFS_IER || aw_addr_q == OFS_FCR || aw_addr_q == OFS_DATA)
                   ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_enable_reg <= IER_RESET;
         fifo_control         <= FCR_RESET;
      end else if (wr_go && w_strb_q[0]) begin
         if (aw_addr_q == OFS_IER)
            interrupt_enable_reg <= w_data_q[7:0];
         if (aw_addr_q == OFS_FCR)
            fifo_control <= w_data_q[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_push <= 1'b0;
         tx_data <= 8'h00;
         rx_pop  <= 1'b0;
      end else begin
         tx_push <= wr_thr;
         rx_pop  <= rd_data;
         if (wr_thr)
            tx_data <= w_data_q[7:0];
      end
   end

   // reads with side effects act once, on the cycle the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (ar_go) begin
         rvalid  <= 1'b1;
         arready <= 1'b0;
         rresp   <= RESP_OKAY;
         unique case (araddr)
            OFS_IER:  rdata <= {24'h000000, interrupt_enable_reg};
            OFS_FCR:  rdata <= {24'h000000, fifo_control};
            OFS_IIR:  rdata <= {26'h0000000, interrupt_ident_reg};
            OFS_LSR:  rdata <= {24'h000000, rx_error_anywhere,
                                tx_count == '0 && tx_shift_empty, tx_count == '0,
                                rx_has_data ? rx_head_errors : 3'h0,
                                overrun_pend, rx_has_data};
            OFS_MSR:  rdata <= {24'h000000, modem_lines, modem_delta};
            OFS_DATA: rdata <= {24'h000000, rx_head_data};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // handshake pin synchronisers

   // a low to high change counts once stages two and three agree
   for (genvar p = 0; p < 2; p++) begin : g_pin
      always_ff @(posedge aclk) begin
         // reset to the inactive high level: an idle pin gives no false rise
         if (!aresetn) begin
            pin_s1[p]     <= 1'b1;
            pin_s2[p]     <= 1'b1;
            pin_s3[p]     <= 1'b1;
            pin_stable[p] <= 1'b1;
         end else begin
            pin_s1[p] <= (p == PIN_CTS) ? cts_n : rts_n;
            pin_s2[p] <= pin_s1[p];
            pin_s3[p] <= pin_s2[p];
            if (pin_s2[p] == pin_s3[p])
               pin_stable[p] <= pin_s3[p];
         end
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge aclk) begin
         if (!aresetn)
            hs_pend[p] <= 1'b0;
         else if (pin_s2[p] && pin_s3[p] && !pin_stable[p])
            hs_pend[p] <= 1'b1;
         else if (rd_iir && grant_q[SRC_HS])
            hs_pend[p] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // interrupt sources

   always_ff @(posedge aclk) begin
      if (!aresetn)
         overrun_pend <= 1'b0;
      else if (overrun_event)
         overrun_pend <= 1'b1;
      else if (rd_lsr)
         overrun_pend <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         tmo_pend <= 1'b0;
      else if (rx_timeout_event)
         tmo_pend <= 1'b1;
      else if (rd_data)
         tmo_pend <= 1'b0;
   end

   // transmit source fires on the rising edge of its condition so a clear sticks
   logic txe_cond;
   assign txe_cond = fifo_en ? (tx_space >= tx_trigger) : (tx_count == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txe_cond_q <= 1'b0;
         txe_pend   <= 1'b0;
      end else begin
         txe_cond_q <= txe_cond;
         if (txe_cond && !txe_cond_q)
            txe_pend <= 1'b1;
         else if (wr_thr || (rd_iir && grant_q[SRC_TXE]))
            txe_pend <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         modem_delta <= 4'h0;
      else
         modem_delta <= modem_change | (rd_msr ? 4'h0 : modem_delta);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flow_pend       <= 1'b0;
         flow_by_special <= 1'b0;
      end else if (flow_stop_event && interrupt_enable_reg[IER_FLOW]) begin
         flow_pend       <= 1'b1;
         flow_by_special <= 1'b0;
      end else if (special_char_event && interrupt_enable_reg[IER_FLOW]) begin
         flow_pend       <= 1'b1;
         flow_by_special <= 1'b1;
      end else if (flow_resume_event && !flow_by_special) begin
         flow_pend       <= 1'b0;
      end else if (rd_iir && grant_q[SRC_FLOW] && flow_by_special) begin
         flow_pend       <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // prioritisation and identification

   always_comb begin
      pending[SRC_LINE]  = interrupt_enable_reg[IER_LINE] && (overrun_pend || rx_error_anywhere);
      pending[SRC_TMO]   = interrupt_enable_reg[IER_RXD] && tmo_pend;
      pending[SRC_RXD]   = interrupt_enable_reg[IER_RXD] &&
                           (fifo_en ? (rx_count >= rx_trigger) : rx_has_data);
      pending[SRC_TXE]   = interrupt_enable_reg[IER_TXE] && txe_pend;
      pending[SRC_MODEM] = interrupt_enable_reg[IER_MODEM] && modem_delta != 4'h0;
      pending[SRC_FLOW]  = interrupt_enable_reg[IER_FLOW] && flow_pend;
      pending[SRC_HS]    = (interrupt_enable_reg[IER_CTS] && hs_pend[PIN_CTS]) ||
                           (interrupt_enable_reg[IER_RTS] && hs_pend[PIN_RTS]);
   end

   uid_prio u_prio (
      .pending (pending),
      .code    (next_code),
      .grant   (next_grant)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_ident_reg <= IIR_RESET;
         grant_q             <= '0;
         irq_n               <= 1'b1;
      end else begin
         interrupt_ident_reg <= next_code;
         grant_q             <= next_grant;
         irq_n               <= pending == '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // dma requests

   // transmit request starts active: the transmitter is empty after reset
   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_dma_request_n <= 1'b0;
      else if (!block_mode)
         tx_dma_request_n <= tx_count != '0;
      else if (tx_count >= CW'(DEPTH))
         tx_dma_request_n <= 1'b1;
      else if (tx_space >= tx_trigger)
         tx_dma_request_n <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         rx_dma_request_n <= 1'b1;
      else if (!block_mode)
         rx_dma_request_n <= !rx_has_data;
      else if (!rx_has_data || rx_error_anywhere)
         rx_dma_request_n <= 1'b1;
      else if (rx_count >= rx_trigger || tmo_pend)
         rx_dma_request_n <= 1'b0;
   end
endmodule : uid_irq_dma

// *** uid_irq_dma_monitor.sv ***
// checker: bus, interrupt and dma request timing at the ports
`timescale 1ns/1ps
module uid_irq_dma_monitor #(
   parameter int DEPTH = 64,
   parameter int CW    = 7
) (
   // clock and reset
   input wire logic          aclk,
   input wire logic          aresetn,
   // register bus
   input wire logic          awvalid,
   input wire logic          awready,
   input wire logic          wvalid,
   input wire logic          wready,
   input wire logic [1:0]    bresp,
   input wire logic          bvalid,
   input wire logic          bready,
   input wire logic [7:0]    araddr,
   input wire logic          arvalid,
   input wire logic          arready,
   input wire logic [31:0]   rdata,
   input wire logic          rvalid,
   input wire logic          rready,
   // status and pins
   input wire logic [CW-1:0] rx_count,
   input wire logic [CW-1:0] tx_count,
   input wire logic          rx_error_anywhere,
   input wire logic          rx_pop,
   input wire logic          tx_push,
   input wire logic [7:0]    fifo_control,
   input wire logic          irq_n,
   input wire logic          tx_dma_request_n,
   input wire logic          rx_dma_request_n
);
   import uid_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic blk;
   // block mode needs the fifos on as well
   assign blk = fifo_control[FCR_DMA_MODE] & fifo_control[FCR_FIFO_EN];
   ////////////////////////////////////////////////////////
   a_reset_idle: assert property (
      $rose(aresetn) |-> irq_n && !tx_dma_request_n && rx_dma_request_n)
      else $error("request pins not idle after reset");
   a_single_tx: assert property (
      $past(aresetn) && !$past(blk) |-> tx_dma_request_n == ($past(tx_count) != 0))
      else $error("single tx request wrong");
   a_single_rx: assert property (
      $past(aresetn) && !$past(blk) |-> rx_dma_request_n == ($past(rx_count) == 0))
      else $error("single rx request wrong");
   a_block_tx_full: assert property (
      $past(aresetn) && $past(blk) && $past(tx_count) >= DEPTH |-> tx_dma_request_n)
      else $error("block tx request on while full");
   a_block_rx_off: assert property (
      $past(aresetn) && $past(blk) && ($past(rx_error_anywhere) || $past(rx_count) == 0)
      |-> rx_dma_request_n)
      else $error("block rx request on while empty or errored");
   a_pop_on_read: assert property (
      $past(aresetn) |-> rx_pop == $past(arvalid && arready && araddr == OFS_DATA))
      else $error("pop not tied to data read");
   a_push_on_write: assert property (
      tx_push |-> bvalid && bresp == RESP_OKAY && !$past(tx_push))
      else $error("push not tied to a data write");
   a_read_answer: assert property (
      arvalid && arready |=> rvalid)
      else $error("read not answered next cycle");
   a_write_answer: assert property (
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write not answered");
   a_resp_hold: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
endmodule : uid_irq_dma_monitor

bind uid_irq_dma uid_irq_dma_monitor #(.DEPTH(DEPTH), .CW(CW)) uid_irq_dma_monitor_i (.*);

// *** uid_host_model.sv ***
// host model: register bus master, one access at a time
`timescale 1ns/1ps
module uid_host_model (
   // clock
   input  wire logic        aclk,
   // write channels
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // read channels
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr} = 16'h0000;
      wdata = 32'h0;
      wstrb = 4'hf;
   end
   ////////////////////////////////////////////////////////
   // each channel released at its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                     output bit to);
      int n;
      n = 0;
      to = 1'b1;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (to && n < 200) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            to = 1'b0;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                     output bit to);
      int n;
      n = 0;
      to = 1'b1;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (to && n < 200) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            to = 1'b0;
         end
      end
   endtask : rd
endmodule : uid_host_model

// *** uid_irq_dma_tb.sv ***
// testbench: interrupt identification and dma requests of one channel
`timescale 1ns/1ps
module uid_irq_dma_tb;
   import uid_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, rx_error_anywhere, overrun_event;
   logic rx_timeout_event, tx_shift_empty, flow_stop_event, flow_resume_event;
   logic special_char_event, cts_n, rts_n, rx_pop, tx_push, irq_n;
   logic tx_dma_request_n, rx_dma_request_n;
   logic [1:0] bresp, rresp, rsp;
   logic [2:0] rx_head_errors;
   logic [3:0] wstrb, modem_change, modem_lines;
   logic [6:0] rx_count, rx_trigger, tx_count, tx_trigger;
   logic [7:0] awaddr, araddr, rx_head_data, tx_data, fifo_control;
   logic [8:0] ev;
   logic [31:0] wdata, rdata, dat;
   int errors, check_count;
   localparam logic [8:0] E_SPC = 9'h001, E_RES = 9'h002, E_STOP = 9'h004;
   localparam logic [8:0] E_TMO = 9'h008, E_OVR = 9'h010, E_MOD = 9'h020;
   assign {modem_change, overrun_event, rx_timeout_event} = ev[8:3];
   assign {flow_stop_event, flow_resume_event, special_char_event} = ev[2:0];
   uid_irq_dma uid_irq_dma_i (.*);
   uid_host_model uid_host_model_i (.*);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : ck
   task automatic step(input int n);
      repeat (n) @(posedge aclk);
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit to;
      uid_host_model_i.wr(a, d, rsp, to);
      errors += int'(to);
      if (to) tally_and_finish();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bit to;
      uid_host_model_i.rd(a, dat, rsp, to);
      errors += int'(to);
      if (to) tally_and_finish();
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      ck(dat, e);
   endtask : rchk
   task automatic id(input logic [5:0] c);
      rchk(OFS_IIR, {26'h0, c});
   endtask : id
   // events are one-cycle pulses; ident settles a cycle later
   task automatic pulse(input logic [8:0] m);
      @(posedge aclk);
      ev <= m;
      @(posedge aclk);
      ev <= 9'h000;
      step(3);
   endtask : pulse
   ////////////////////////////////////////////////////////
   task automatic t_reset;
      id(CODE_NONE);
      rchk(OFS_IER, 32'h0);
      rchk(OFS_FCR, 32'h0);
      ck({31'h0, irq_n}, 32'h1);
   endtask : t_reset
   task automatic t_polled;
      pulse(E_OVR);
      ck({31'h0, irq_n}, 32'h1);
      rchk(OFS_LSR, 32'h02);
      id(CODE_NONE);
   endtask : t_polled
   task automatic t_prio;
      wr(OFS_IER, 32'hef);
      pulse(E_OVR | E_MOD);
      ck({31'h0, irq_n}, 32'h0);
      id(CODE_LINE);
      rchk(OFS_LSR, 32'h02);
      id(CODE_MODEM);
      rchk(OFS_MSR, 32'h01);
      id(CODE_NONE);
      ck({31'h0, irq_n}, 32'h1);
   endtask : t_prio
   task automatic t_tx;
      tx_count <= 7'h00;
      step(3);
      ck({31'h0, tx_dma_request_n}, 32'h0);
      id(CODE_TXE);
      id(CODE_NONE);
      tx_count <= 7'h01;
      step(2);
      ck({31'h0, tx_dma_request_n}, 32'h1);
      tx_count <= 7'h00;
      step(3);
      wr(OFS_DATA, 32'h5a);
      ck({23'h0, tx_push, tx_data}, 32'h15a);
      id(CODE_NONE);
      tx_count <= 7'h01;
   endtask : t_tx
   task automatic t_rx;
      rx_count <= 7'h01;
      step(3);
      ck({31'h0, rx_dma_request_n}, 32'h0);
      id(CODE_RXD);
      rchk(OFS_DATA, 32'ha5);
      rx_count <= 7'h00;
      step(3);
      ck({31'h0, rx_dma_request_n}, 32'h1);
      pulse(E_TMO);
      id(CODE_TMO);
      rd(OFS_DATA);
      id(CODE_NONE);
   endtask : t_rx
   task automatic t_lsr;
      rx_count <= 7'h01;
      rx_head_errors <= 3'h5;
      rx_error_anywhere <= 1'b1;
      step(3);
      rchk(OFS_LSR, 32'h95);
      id(CODE_LINE);
      rx_count <= 7'h00;
      rx_error_anywhere <= 1'b0;
      step(3);
      rchk(OFS_LSR, 32'h00);
      id(CODE_NONE);
   endtask : t_lsr
   task automatic t_flow;
      pulse(E_STOP);
      id(CODE_FLOW);
      pulse(E_RES);
      id(CODE_NONE);
      pulse(E_SPC);
      id(CODE_FLOW);
      id(CODE_NONE);
      wr(OFS_IER, 32'h0f);
      pulse(E_STOP);
      id(CODE_NONE);
   endtask : t_flow
   task automatic t_hs;
      wr(OFS_IER, 32'hc0);
      for (int p = 1; p < 3; p++) begin
         {rts_n, cts_n} <= 2'(p);
         step(8);
         ck({31'h0, irq_n}, 32'h0);
         id(CODE_HS);
         id(CODE_NONE);
         {rts_n, cts_n} <= 2'h0;
         step(8);
      end
   endtask : t_hs
   task automatic t_dma;
      wr(OFS_FCR, 32'h09);
      rchk(OFS_FCR, 32'h09);
      tx_count <= 7'h40;
      step(3);
      ck({31'h0, tx_dma_request_n}, 32'h1);
      tx_count <= 7'h0a;
      rx_count <= 7'h08;
      step(3);
      ck({30'h0, tx_dma_request_n, rx_dma_request_n}, 32'h0);
      rx_error_anywhere <= 1'b1;
      step(3);
      ck({31'h0, rx_dma_request_n}, 32'h1);
      rx_error_anywhere <= 1'b0;
      wr(OFS_FCR, 32'h01);
      step(2);
      ck({30'h0, tx_dma_request_n, rx_dma_request_n}, 32'h2);
      {tx_count, rx_count} <= {7'h01, 7'h00};
      wr(OFS_FCR, 32'h00);
   endtask : t_dma
   task automatic t_bus;
      rd(8'h40);
      ck({dat[29:0], rsp}, {30'h0, RESP_SLVERR});
      wr(OFS_IIR, 32'h3f);
      ck({30'h0, rsp}, {30'h0, RESP_SLVERR});
      id(CODE_NONE);
   endtask : t_bus
   ////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      ev = 9'h000;
      {rx_error_anywhere, cts_n, rts_n, modem_lines, rx_head_errors} = 10'h000;
      {rx_count, tx_count, rx_trigger, tx_trigger} = {7'h00, 7'h01, 7'h08, 7'h08};
      rx_head_data = 8'ha5;
      tx_shift_empty = 1'b1;
      errors = 0;
      check_count = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_polled();
      t_prio();
      t_tx();
      t_rx();
      t_lsr();
      t_flow();
      t_hs();
      t_dma();
      t_bus();
      tally_and_finish();
   end
endmodule : uid_irq_dma_tb
